//--- rtl/ssrp_pkg.sv
// Shared constants and types for the serial register port and its controller
package ssrp_pkg;
   // Link command codes
   localparam logic [7:0] CMD_READ  = 8'h03;
   localparam logic [7:0] CMD_WRITE = 8'h02;
   // Register array
   localparam int         REG_COUNT   = 128;
   localparam logic [6:0] START_REG   = 7'h01;
   localparam int         START_BIT   = 0;
   localparam logic [1:0] STRAP_SPI   = 2'h2;
   localparam logic [2:0] STRAP_WAIT  = 3'h6;
   // Timing: the link may run at 5 MHz at most
   localparam int CLK_PERIOD_NS   = 20;
   localparam int SCLK_MAX_HZ     = 5000000;
   localparam int SCLK_MIN_HALF_NS = 1000000000 / SCLK_MAX_HZ / 2;
   // Controller runs at half the top rate to cover the sampling latency
   localparam int SCLK_HALF_NS    = 2 * SCLK_MIN_HALF_NS;
   localparam int SCLK_HALF_CYC_I =
      (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_HALF_CYC_I);
   // Controller registers on the AHB-Lite bus (byte addresses)
   localparam logic [3:0] HOST_CTRL_OFS   = 4'h0;
   localparam logic [3:0] HOST_DATA_OFS   = 4'h4;
   localparam logic [3:0] HOST_STATUS_OFS = 4'h8;
   // Control word fields
   localparam int CTRL_GO_BIT   = 0;
   localparam int CTRL_WR_BIT   = 1;
   localparam int CTRL_ADDR_LSB = 8;
   localparam int CTRL_CNT_LSB  = 16;
   // Phases of the device end
   typedef enum logic [1:0] {
      DEV_CMD, DEV_ADDR, DEV_DATA, DEV_SKIP
   } ssrp_dev_phase_type;
   // Phases of the controller end
   typedef enum logic [2:0] {
      HOST_IDLE, HOST_SETUP, HOST_LOW, HOST_HIGH, HOST_WAIT, HOST_END
   } ssrp_host_phase_type;
endpackage

//--- rtl/ssrp_link_if.sv
// Four-wire serial link between the controller and the register port
`timescale 1ns/1ps
`default_nettype none
interface ssrp_link_if;
   logic slave_select_n;
   logic serial_clock_in;
   logic serial_in_from_master;
   logic serial_out_to_master;
   logic serial_out_oe;
   logic serial_out_line;
   // Undriven return line floats high through a board pull-up
   assign serial_out_line = serial_out_oe ? serial_out_to_master : 1'b1;
   modport dev (
      input  slave_select_n,
      input  serial_clock_in,
      input  serial_in_from_master,
      output serial_out_to_master,
      output serial_out_oe
   );
   modport host (
      output slave_select_n,
      output serial_clock_in,
      output serial_in_from_master,
      input  serial_out_line
   );
endinterface
`default_nettype wire

//--- rtl/ssrp_sync.sv
// Three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module ssrp_sync
   import ssrp_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // Raw pins in, filtered level and edges out
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] lvl,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } ssrp_sync_state_type;

   ssrp_sync_state_type s;
   ssrp_sync_state_type next_s;

   // Level moves only when stages two and three agree
   always_comb begin
      next_s     = s;
      next_s.s1  = din;
      next_s.s2  = s.s1;
      next_s.s3  = s.s2;
      next_s.lvl = (s.s2 & s.s3) | (s.lvl & (s.s2 | s.s3));
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign lvl = s.lvl;

   // Edge pulses come one cycle ahead of the level update
   for (genvar i = 0; i < W; i++) begin : g_edge
      assign rise[i] = s.s2[i] & s.s3[i] & ~s.lvl[i];
      assign fall[i] = ~s.s2[i] & ~s.s3[i] & s.lvl[i];
   end
endmodule
`default_nettype wire

//--- rtl/ssrp_dev.sv
// Serial register port: slave end holding the 128 configuration registers
`timescale 1ns/1ps
`default_nettype none
module ssrp_dev
   import ssrp_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Serial link
   ssrp_link_if.dev        link,
   // Strap pins
   input  wire logic [1:0] port_select_strap,
   // Switch core side
   input  wire logic [6:0] user_addr,
   output logic      [7:0] user_data,
   output logic            start_switch
);
   typedef struct packed {
      logic [REG_COUNT-1:0][7:0] regs;
      logic [7:0]                shift_in;
      logic [2:0]                bit_cnt;
      ssrp_dev_phase_type        phase;
      logic                      is_write;
      logic [6:0]                addr;
      logic [7:0]                tx;
      logic                      miso;
      logic                      oe;
      logic [2:0]                strap_wait;
      logic                      strap_ok;
      logic [7:0]                user_data;
   } ssrp_dev_state_type;

   ssrp_dev_state_type s;
   ssrp_dev_state_type next_s;

   logic [4:0] pin_lvl;
   logic [4:0] pin_rise;
   logic [4:0] pin_fall;
   logic       sel_n;
   logic       sck_rise;
   logic       sck_fall;
   logic       mosi;
   logic [7:0] rx_byte;

   // All pins come from outside this clock domain
   ssrp_sync #(.W(5)) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .din    ({port_select_strap, link.slave_select_n,
                link.serial_clock_in, link.serial_in_from_master}),
      .lvl    (pin_lvl),
      .rise   (pin_rise),
      .fall   (pin_fall)
   );

   assign sel_n    = pin_lvl[2];
   assign sck_rise = pin_rise[1];
   assign sck_fall = pin_fall[1];
   assign mosi     = pin_lvl[0];
   assign rx_byte  = {s.shift_in[6:0], mosi};

   // Byte assembly, command decode and register access
   always_comb begin
      next_s           = s;
      next_s.user_data = s.regs[user_addr];
      // Strap is caught once the filter has settled after reset; the
      // filtered level needs four edges, so earlier looks would see zero
      if (s.strap_wait != STRAP_WAIT) begin
         next_s.strap_wait = s.strap_wait + 3'h1;
         next_s.strap_ok   = (pin_lvl[4:3] == STRAP_SPI);
      end
      if (sel_n || !s.strap_ok) begin
         // Deselect ends any burst and resyncs the byte framing
         next_s.phase   = DEV_CMD;
         next_s.bit_cnt = 3'h0;
         next_s.oe      = 1'b0;
         next_s.miso    = 1'b0;
      end else begin
         next_s.oe = 1'b1;
         if (sck_rise) begin
            next_s.shift_in = rx_byte;
            next_s.bit_cnt  = s.bit_cnt + 3'h1;
            if (s.bit_cnt == 3'h7) begin
               unique case (s.phase)
                  DEV_CMD: begin
                     // Unknown commands are ignored to end of frame
                     if (rx_byte == CMD_WRITE) begin
                        next_s.phase    = DEV_ADDR;
                        next_s.is_write = 1'b1;
                     end else if (rx_byte == CMD_READ) begin
                        next_s.phase    = DEV_ADDR;
                        next_s.is_write = 1'b0;
                     end else begin
                        next_s.phase = DEV_SKIP;
                     end
                  end
                  DEV_ADDR: begin
                     next_s.addr  = rx_byte[6:0];
                     next_s.phase = DEV_DATA;
                  end
                  DEV_DATA: begin
                     if (s.is_write) begin
                        // No lock after start: settings stay live
                        next_s.regs[s.addr] = rx_byte;
                        if (s.addr == START_REG) begin
                           next_s.regs[s.addr][START_BIT] =
                              rx_byte[START_BIT] |
                              s.regs[START_REG][START_BIT];
                        end
                     end
                     // Seven-bit counter wraps 127 to 0
                     next_s.addr = s.addr + 7'h1;
                  end
                  DEV_SKIP: begin
                     next_s.phase = DEV_SKIP;
                  end
               endcase
            end
         end
         if (sck_fall && s.phase == DEV_DATA && !s.is_write) begin
            if (s.bit_cnt == 3'h0) begin
               // Byte boundary: load the register at the current address
               next_s.miso = s.regs[s.addr][7];
               next_s.tx   = {s.regs[s.addr][6:0], 1'b0};
            end else begin
               next_s.miso = s.tx[7];
               next_s.tx   = {s.tx[6:0], 1'b0};
            end
         end
      end
   end

   // All registers, the start bit among them, clear on reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign link.serial_out_to_master = s.miso;
   assign link.serial_out_oe        = s.oe;
   assign user_data                 = s.user_data;
   assign start_switch              = s.regs[START_REG][START_BIT];
endmodule
`default_nettype wire

//--- rtl/ssrp_host.sv
// Serial link controller with an AHB-Lite register slave for software
// Contract
// - Command 03h reads, 02h writes.
// - Held select continues read at next address.
// - Held select continues write at next address.
// - Address counter wraps to zero after top.
// - All 128 registers reachable, tables via window.
// - Link clock up to 5 MHz.
// - Read data changes on falling link clock.
// - Input data captured on rising link clock.
// - Port active only when strap reads 10.
// - Reset clears the start-switch bit.
// - Start-switch bit cannot be cleared by writes.
// - Master verifies settings before starting switch.
// - Registers stay writable after switch start.
// - Master gets full read/write register access.
`timescale 1ns/1ps
`default_nettype none
module ssrp_host
   import ssrp_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // Serial link
   ssrp_link_if.host        link
);
   typedef struct packed {
      logic                ap_valid;
      logic [3:0]          ap_addr;
      logic [31:0]         hrdata;
      logic                hreadyout;
      logic                is_write;
      logic [6:0]          addr;
      logic [8:0]          remaining;
      logic [7:0]          tx_data;
      logic                tx_full;
      logic [7:0]          rx_data;
      logic                rx_full;
      logic                have_rx;
      ssrp_host_phase_type phase;
      logic [3:0]          timer;
      logic [2:0]          bit_cnt;
      logic [1:0]          byte_idx;
      logic [7:0]          out_byte;
      logic [7:0]          rx_shift;
      logic                ss_n;
      logic                sclk;
      logic                mosi;
   } ssrp_host_state_type;

   ssrp_host_state_type s;
   ssrp_host_state_type next_s;

   logic miso;
   logic busy;

   // Return data arrives from outside this clock domain
   ssrp_sync #(.W(1)) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .din    (link.serial_out_line),
      .lvl    (miso),
      .rise   (),
      .fall   ()
   );

   assign busy = (s.phase != HOST_IDLE);

   always_comb begin
      next_s           = s;
      next_s.hreadyout = 1'b1;
      // Bus address phase: read data is formed here for the data phase
      next_s.ap_valid  = hsel & htrans[1] & hready & hwrite;
      next_s.ap_addr   = haddr[3:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
         unique case (haddr[3:0])
            HOST_DATA_OFS: begin
               next_s.hrdata  = {24'h0, s.rx_data};
               next_s.rx_full = 1'b0;
            end
            HOST_STATUS_OFS: next_s.hrdata = {29'h0, s.rx_full,
                                              s.tx_full, busy};
            HOST_CTRL_OFS: next_s.hrdata = {8'h0,
                                            s.remaining[7:0] - 8'h1,
                                            1'b0, s.addr, 6'h0,
                                            s.is_write, 1'b0};
            default: next_s.hrdata = 32'h0;
         endcase
      end
      // Bus write data phase
      if (s.ap_valid) begin
         if (s.ap_addr == HOST_DATA_OFS) begin
            next_s.tx_data = hwdata[7:0];
            next_s.tx_full = 1'b1;
         end else if (s.ap_addr == HOST_CTRL_OFS && !busy &&
                      hwdata[CTRL_GO_BIT]) begin
            // A start while busy is dropped
            next_s.is_write  = hwdata[CTRL_WR_BIT];
            next_s.addr      = hwdata[CTRL_ADDR_LSB +: 7];
            next_s.remaining = {1'b0, hwdata[CTRL_CNT_LSB +: 8]} + 9'h1;
            next_s.phase     = HOST_SETUP;
            next_s.ss_n      = 1'b0;
            next_s.timer     = SCLK_HALF_CYC - 4'h1;
         end
      end
      // Link sequencer; the link clock is divided down from clk
      unique case (s.phase)
         HOST_IDLE: next_s.ss_n = 1'b1;
         HOST_SETUP: begin
            // The idle branch held select high on the start cycle
            next_s.ss_n = 1'b0;
            if (s.timer == 4'h0) begin
               next_s.out_byte = s.is_write ? CMD_WRITE : CMD_READ;
               next_s.byte_idx = 2'h0;
               next_s.phase    = HOST_LOW;
               next_s.bit_cnt  = 3'h0;
               next_s.mosi     = next_s.out_byte[7];
               next_s.timer    = SCLK_HALF_CYC - 4'h1;
            end else begin
               next_s.timer = s.timer - 4'h1;
            end
         end
         HOST_LOW: begin
            if (s.timer == 4'h0) begin
               next_s.sclk     = 1'b1;
               next_s.rx_shift = {s.rx_shift[6:0], miso};
               next_s.phase    = HOST_HIGH;
               next_s.timer    = SCLK_HALF_CYC - 4'h1;
            end else begin
               next_s.timer = s.timer - 4'h1;
            end
         end
         HOST_HIGH: begin
            if (s.timer == 4'h0) begin
               next_s.sclk  = 1'b0;
               next_s.timer = SCLK_HALF_CYC - 4'h1;
               if (s.bit_cnt == 3'h7) begin
                  next_s.phase = HOST_WAIT;
                  if (s.byte_idx == 2'h2) begin
                     next_s.remaining = s.remaining - 9'h1;
                     next_s.have_rx   = !s.is_write;
                  end
               end else begin
                  next_s.bit_cnt  = s.bit_cnt + 3'h1;
                  next_s.mosi     = s.out_byte[6];
                  next_s.out_byte = {s.out_byte[6:0], 1'b0};
                  next_s.phase    = HOST_LOW;
               end
            end else begin
               next_s.timer = s.timer - 4'h1;
            end
         end
         HOST_WAIT: begin
            // Select stays low while waiting: the burst continues
            next_s.timer   = SCLK_HALF_CYC - 4'h1;
            next_s.bit_cnt = 3'h0;
            if (s.have_rx) begin
               if (!s.rx_full) begin
                  next_s.rx_data = s.rx_shift;
                  next_s.rx_full = 1'b1;
                  next_s.have_rx = 1'b0;
               end
            end else if (s.byte_idx == 2'h0) begin
               next_s.out_byte = {1'b0, s.addr};
               next_s.byte_idx = 2'h1;
               next_s.mosi     = 1'b0;
               next_s.phase    = HOST_LOW;
            end else if (s.remaining == 9'h0) begin
               next_s.phase = HOST_END;
            end else if (s.is_write && s.tx_full) begin
               next_s.out_byte = s.tx_data;
               next_s.mosi     = s.tx_data[7];
               // A data write landing in this cycle keeps the slot full
               next_s.tx_full  = s.ap_valid &&
                                 (s.ap_addr == HOST_DATA_OFS);
               next_s.byte_idx = 2'h2;
               next_s.phase    = HOST_LOW;
            end else if (!s.is_write) begin
               next_s.out_byte = 8'h00;
               next_s.mosi     = 1'b0;
               next_s.byte_idx = 2'h2;
               next_s.phase    = HOST_LOW;
            end
         end
         HOST_END: begin
            if (s.timer == 4'h0) begin
               next_s.ss_n  = 1'b1;
               next_s.mosi  = 1'b0;
               next_s.phase = HOST_IDLE;
            end else begin
               next_s.timer = s.timer - 4'h1;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register, hresp tied to OKAY
   assign hreadyout                  = s.hreadyout;
   assign hresp                      = 1'b0;
   assign hrdata                     = s.hrdata;
   assign link.slave_select_n        = s.ss_n;
   assign link.serial_clock_in       = s.sclk;
   assign link.serial_in_from_master = s.mosi;
endmodule
`default_nettype wire

//--- dv/ssrp_monitor.sv
// Protocol checker for the serial link between controller and port
`timescale 1ns/1ps
`default_nettype none
module ssrp_monitor (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Link wires
   input  wire logic slave_select_n,
   input  wire logic serial_clock_in,
   input  wire logic serial_in_from_master,
   input  wire logic serial_out_to_master,
   input  wire logic serial_out_oe
);
   logic [9:0] bit_cnt;
   logic       sclk_d;

   // Count link clock rises per frame; cleared while deselected
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bit_cnt <= 10'h000;
         sclk_d  <= 1'b0;
      end else begin
         sclk_d <= serial_clock_in;
         if (slave_select_n)
            bit_cnt <= 10'h000;
         else if (serial_clock_in && !sclk_d)
            bit_cnt <= bit_cnt + 10'h001;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // Each link clock level lasts long enough for the port to sample it
   sequence s_high_hold;
      serial_clock_in [*8];
   endsequence
   sequence s_low_hold;
      !serial_clock_in [*8];
   endsequence

   a_clk_high_width: assert property (
      $rose(serial_clock_in) |-> s_high_hold)
      else $error("link clock high phase too short");
   a_clk_low_width: assert property (
      $fell(serial_clock_in) |-> s_low_hold)
      else $error("link clock low phase too short");
   a_select_setup: assert property (
      $fell(slave_select_n) |-> s_low_hold)
      else $error("link clock moved too soon after select");
   a_idle_clock_low: assert property (
      slave_select_n |-> !serial_clock_in)
      else $error("link clock not low outside a frame");
   a_in_stable_high: assert property (
      serial_clock_in && $past(serial_clock_in)
      |-> $stable(serial_in_from_master))
      else $error("master data moved while link clock high");
   a_out_on_fall: assert property (
      $changed(serial_out_to_master) && serial_out_oe
      |-> !serial_clock_in && !$past(serial_clock_in, 3))
      else $error("read data moved outside a falling edge");
   a_byte_frames: assert property (
      $rose(slave_select_n) && bit_cnt != 10'h000
      |-> bit_cnt[2:0] == 3'h0 && bit_cnt >= 10'h018)
      else $error("frame not whole bytes of command address data");
   a_out_released: assert property (
      slave_select_n [*8] |-> !serial_out_oe)
      else $error("port drives read line while deselected");
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench: controller and register port joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb
   import ssrp_pkg::*;
;
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] data;
   } ssrp_row_type;
   logic         clk;
   logic         resetn;
   logic         hsel;
   logic [31:0]  haddr;
   logic [1:0]   htrans;
   logic         hwrite;
   logic [2:0]   hsize;
   logic [31:0]  hwdata;
   logic         hreadyout;
   logic         hresp;
   logic [31:0]  hrdata;
   logic [1:0]   strap;
   logic [6:0]   user_addr;
   logic [7:0]   user_data;
   logic         start_switch;
   logic [31:0]  rd;
   logic [7:0]   txq[$];
   logic [7:0]   rxq[$];
   int           failures;
   int           check_count;
   ssrp_row_type rows[6] = '{'{7'h00, 8'h5a}, '{7'h02, 8'ha5},
      '{7'h01, 8'h80}, '{7'h6e, 8'h3c}, '{7'h78, 8'hc3}, '{7'h7f, 8'hff}};

   ssrp_link_if link ();
   ssrp_host u_ssrp_host (.clk(clk), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .link(link.host));
   ssrp_dev u_ssrp_dev (.clk(clk), .resetn(resetn), .link(link.dev),
      .port_select_strap(strap), .user_addr(user_addr),
      .user_data(user_data), .start_switch(start_switch));
   ssrp_monitor u_ssrp_monitor (.clk(clk), .resetn(resetn),
      .slave_select_n(link.slave_select_n),
      .serial_clock_in(link.serial_clock_in),
      .serial_in_from_master(link.serial_in_from_master),
      .serial_out_to_master(link.serial_out_to_master),
      .serial_out_oe(link.serial_out_oe));

   // Free-running system clock
   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   // Compare, count, and report a mismatch at once
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Print the counts and the verdict, then stop
   task automatic report_and_stop();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Strap is set before reset, since the port reads it only in the six cycles after
   task automatic do_reset(input logic [1:0] s);
      strap  <= s;
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      repeat (10) @(posedge clk);
   endtask

   // One single AHB-Lite word transfer, entered just after a rising edge
   task automatic ahb(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // Poll status until a flag reaches a level; the watchdog bounds it
   task automatic wait_flag(input int idx, input logic val);
      do ahb(1'b0, {28'h0, HOST_STATUS_OFS}, 32'h0);
      while (rd[idx] !== val);
   endtask

   // One frame: control word, then bytes through the data register
   task automatic frame(input logic wr, input logic [6:0] a, input int n);
      ahb(1'b1, {28'h0, HOST_CTRL_OFS},
          {8'h00, 8'(n - 1), 1'b0, a, 6'h00, wr, 1'b1});
      for (int i = 0; i < n; i++) begin
         if (wr) begin
            wait_flag(1, 1'b0);
            ahb(1'b1, {28'h0, HOST_DATA_OFS}, {24'h0, txq.pop_front()});
         end else begin
            wait_flag(2, 1'b1);
            ahb(1'b0, {28'h0, HOST_DATA_OFS}, 32'h0);
            rxq.push_back(rd[7:0]);
         end
      end
      wait_flag(0, 1'b0);
   endtask

   // Look at a register from the switch core side (one cycle latency)
   task automatic peek(input logic [6:0] a);
      user_addr <= a;
      repeat (2) @(posedge clk);
   endtask

   // Hang guard, well beyond the expected run length
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      report_and_stop();
   end

   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      strap = STRAP_SPI;
      user_addr = 7'h00;
      failures = 0;
      check_count = 0;
      do_reset(STRAP_SPI);
      // Table of single writes, read back over the link and at the core
      foreach (rows[i]) begin
         txq.push_back(rows[i].data);
         frame(1'b1, rows[i].addr, 1);
         frame(1'b0, rows[i].addr, 1);
         chk("link read", 32'(rows[i].data), 32'(rxq.pop_front()));
         peek(rows[i].addr);
         chk("core copy", 32'(rows[i].data), 32'(user_data));
      end
      chk("start idle", 32'h0, 32'(start_switch));
      $display("test single_access done");
      // Start bit is sticky, other bits of the register stay writable
      txq.push_back(8'h01);
      frame(1'b1, START_REG, 1);
      txq.push_back(8'h40);
      frame(1'b1, START_REG, 1);
      frame(1'b0, START_REG, 1);
      chk("start reg", 32'h41, 32'(rxq.pop_front()));
      chk("start on", 32'h1, 32'(start_switch));
      $display("test start_sticky done");
      // A second reset clears the start bit again
      do_reset(STRAP_SPI);
      peek(START_REG);
      chk("start reg reset", 32'h0, 32'(user_data));
      chk("start reset", 32'h0, 32'(start_switch));
      $display("test reset done");
      // Bursts across the top address wrap to register zero
      txq = '{8'h11, 8'h22, 8'h33, 8'h44};
      frame(1'b1, 7'h7d, 4);
      frame(1'b0, 7'h7e, 3);
      for (int i = 0; i < 3; i++)
         chk("burst read", 32'(8'h22 + 8'h11 * i), 32'(rxq.pop_front()));
      peek(7'h00);
      chk("wrapped write", 32'h44, 32'(user_data));
      $display("test burst_wrap done");
      // Wrong strap: port ignores frames, read line floats high
      do_reset(2'h0);
      txq.push_back(8'h99);
      frame(1'b1, 7'h05, 1);
      frame(1'b0, 7'h05, 1);
      chk("strap off read", 32'hff, 32'(rxq.pop_front()));
      peek(7'h05);
      chk("strap off store", 32'h0, 32'(user_data));
      $display("test strap_off done");
      // Unmapped controller address reads zero with an OKAY response
      ahb(1'b0, 32'h0000000c, 32'h0);
      chk("unmapped read", 32'h0, rd);
      chk("response", 32'h0, 32'(hresp));
      $display("test unmapped done");
      report_and_stop();
   end
endmodule
`default_nettype wire
